//--- i2c_master_timing_tenbit_tb.sv
`include "serial_master_defs.vh"
module i2c_master_timing_tenbit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hold = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  logic [7:0] exp_b [0:6] = '{8'hf2, 8'h5c, 8'h11, 8'h22, 8'hf4, 8'h5c, 8'hf5};
  wire [31:0] rdat;
  wire ack, scl_oe, sda_oe, slv_scl, slv_sda;
  wire scl = !(scl_oe || slv_scl);
  wire sda = !(sda_oe || slv_sda);
  int num_errors = 0;
  int checks_done = 0;
  always #4 i_clk_sys = !i_clk_sys;
  serial_master dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_scl(scl), .o_scl(), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda(),
    .o_sda_oe(sda_oe));
  twowire_slave slv (.i_scl(scl), .i_sda(sda), .i_hold(hold), .o_scl_low(slv_scl),
    .o_sda_low(slv_sda));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clk_sys); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  // polling is bounded by the watchdog, not here
  task automatic wait_stat(input int b);
    do bus(1'b0, `STAT_OFS, 32'h0); while (q[b] !== 1'b1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    rd(`RATE_OFS, 32'h5dc, "rate");
    rd(`EDGE_OFS, 32'h0030_0030, "edge");
    rd(`LIMIT_OFS, 32'h40, "limit");
    rd(`STAT_OFS, 32'h0, "status");
    rd(8'h20, 32'h0, "unmapped");
    wr(`LIMIT_OFS, 32'hffff_0002);
    rd(`LIMIT_OFS, 32'h2, "limit");
    wr(`RATE_OFS, 32'hffff_0021);
    rd(`RATE_OFS, 32'h21, "rate");
    wr(`EDGE_OFS, 32'h0004_0005);
    wr(`COUNT_OFS, 32'h3);
    wr(`FIFO_OFS, 32'h5c);
    wr(`FIFO_OFS, 32'h11);
    wr(`FIFO_OFS, 32'h22);
    rd(`COUNT_OFS, 32'h3, "count");
    wr(`ADDR_OFS, 32'h79);
    wr(`CTRL_OFS, 32'h80);
    rd(`STAT_OFS, 32'h1, "active");
    wait_stat(`STAT_DONE_BIT);
    rd(`STAT_OFS, 32'h2, "idle");
    rd(`COUNT_OFS, 32'h0, "count");
    wr(`STAT_OFS, 32'h2);
    wr(`COUNT_OFS, 32'h1);
    wr(`FIFO_OFS, 32'h5c);
    wr(`ADDR_OFS, 32'h7a);
    wr(`CTRL_OFS, 32'h80);
    wait_stat(`STAT_ACTIVE_BIT);
    wr(`COUNT_OFS, 32'h2);
    wr(`CTRL_OFS, 32'h81);
    wait_stat(`STAT_DONE_BIT);
    wr(`STAT_OFS, 32'h2);
    rd(`FIFO_OFS, 32'ha5, "rx0");
    rd(`FIFO_OFS, 32'ha6, "rx1");
    chk("bytes", 32'h7, slv.seen_n);
    foreach (exp_b[i]) chk("byte", {24'h0, exp_b[i]}, {24'h0, slv.seen[i]});
    wr(`COUNT_OFS, 32'h0);
    wr(`CTRL_OFS, 32'h80);
    hold <= 1'b1;
    wait_stat(`STAT_DONE_BIT);
    hold <= 1'b0;
    chk("flag", 32'h1, {31'h0, q[`STAT_STRETCH_LIMIT_REG_BIT]});
    wr(`STAT_OFS, 32'h0);
    rd(`STAT_OFS, 32'h302, "flag kept");
    wr(`STAT_OFS, 32'h302);
    rd(`STAT_OFS, 32'h0, "cleared");
    wr(`LIMIT_OFS, 32'h0);
    wr(`CTRL_OFS, 32'h80);
    hold <= 1'b1;
    repeat (2000) @(posedge i_clk_sys);
    rd(`STAT_OFS, 32'h1, "stalled");
    hold <= 1'b0;
    wait_stat(`STAT_DONE_BIT);
    wr(`STAT_OFS, 32'h302);
    // a stale byte must not survive the fifo clear
    wr(`FIFO_OFS, 32'h33);
    wr(`CTRL_OFS, 32'h10);
    wr(`FIFO_OFS, 32'h44);
    rd(`FIFO_OFS, 32'h44, "fifo clear");
    final_report;
  end
endmodule // i2c_master_timing_tenbit_tb

//--- serial_master.v
// Operation
// - serial clock frequency is core clock divided by the 16-bit ratio field
// - ratio zero divides the core clock by 32768
// - ratio least significant bit ignored, divisor always even
// - ratio resets to 0x5dc, about 100 kHz
// - wait rise_sample_wait core clocks after rising edge, then sample data
// - wait fall_launch_wait core clocks after falling edge, then drive data
// - count stretched serial periods up to stretch_limit, then move on
// - stretch timeout sets stretch_timeout_flag in status
// - stretch_limit zero disables stretch timeout detection
// - ten-bit first byte is 11110, two top bits, then read/write; the engine sends the 7-bit address register, then read/write
// - after write first byte comes low address byte; after read, slave data; the engine sends the next fifo byte after a write first byte
// - go with read while active gives repeated start and read address
// - stretch_timeout_flag stays set until software writes one
// - status shows transfer_in_progress while a transfer runs
// - byte_count sets bytes to move; reads while busy give bytes left
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`include "serial_master_defs.vh"
module serial_master #(
  parameter AW = 8,
  parameter DEPTH_LOG2 = 4
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [AW-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire i_scl,
  output reg o_scl,
  output reg o_scl_oe,
  input wire i_sda,
  output reg o_sda,
  output reg o_sda_oe
);
  localparam S_IDLE = 4'b0001;
  localparam S_START = 4'b0010;
  localparam S_BIT = 4'b0100;
  localparam S_STOP = 4'b1000;
  localparam DEPTH = 1 << DEPTH_LOG2;

  reg [3:0] state_r;
  reg [1:0] ph_r;
  reg [15:0] cnt_r;
  reg [3:0] bitn_r;
  reg [7:0] sh_r;
  reg hi_r;
  reg samp_r;
  reg addr_ph_r;
  reg rd_r;
  reg rs_pend_r;
  reg [15:0] remain_r;
  reg [15:0] str_cnt_r;
  reg [15:0] str_per_r;
  reg done_r;
  reg err_r;
  reg stretch_limit_reg_r;
  reg ctl_read_r;
  reg [6:0] addr_r;
  reg [15:0] count_wr_r;
  reg [15:0] scl_ratio_r;
  reg [15:0] rise_sample_wait_r;
  reg [15:0] fall_launch_wait_r;
  reg [15:0] stretch_limit_r;
  reg [2:0] scl_q_r;
  reg [2:0] sda_q_r;
  reg scl_s_r;
  reg sda_s_r;
  reg [7:0] mem_r [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wp_r;
  reg [DEPTH_LOG2:0] rp_r;

  // bus decode; writes and pops act on the cycle the request is taken
  wire req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = req & i_wb_we;
  wire rdq = req & ~i_wb_we;
  wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] wd = i_wb_dat & wmask;
  wire wr_ctrl = wr & (i_wb_adr[7:0] == `CTRL_OFS);
  wire wr_stat = wr & (i_wb_adr[7:0] == `STAT_OFS);
  wire go = wr_ctrl & wd[`CTRL_GO_BIT];
  wire fifo_clr = wr_ctrl & wd[`CTRL_CLEAR_BIT];
  // go sees the read bit written in the same cycle
  wire ctl_read_r_nxt = (wr_ctrl & i_wb_sel[0]) ? i_wb_dat[`CTRL_READ_BIT] : ctl_read_r;
  wire [6:0] addr_r_nxt = addr_r;

  wire fifo_empty = (wp_r == rp_r);
  wire fifo_full = ((wp_r ^ rp_r) == {1'b1, {DEPTH_LOG2{1'b0}}});
  wire [7:0] fifo_q = mem_r[rp_r[DEPTH_LOG2-1:0]];
  wire active = ~state_r[0];

  wire [15:0] even_ratio = {scl_ratio_r[15:1], 1'b0};
  wire [15:0] div = (even_ratio == 16'h0000) ? `RATE_ZERO_DIV : even_ratio;
  wire [15:0] half_m1 = {1'b0, div[15:1]} - 16'h0001;
  wire [15:0] div_m1 = div - 16'h0001;

  wire in_bit = (state_r == S_BIT);
  wire byte_start = in_bit & (ph_r == 2'd0) & (bitn_r == 4'd0) & (cnt_r == 16'h0000) & ~addr_ph_r;
  // hold the clock low at a byte boundary until the fifo can serve it
  wire stall = byte_start & (rd_r ? fifo_full : fifo_empty);
  wire ld_now = byte_start & ~rd_r & ~fifo_empty;
  wire txbit = ld_now ? fifo_q[7] : sh_r[7];
  wire we_send = addr_ph_r | ~rd_r;
  wire drive_low = (bitn_r < 4'd8) ? (we_send & ~txbit) : (~we_send & (remain_r != 16'h0001));
  wire hi_end = in_bit & (ph_r == 2'd1) & hi_r & (cnt_r == half_m1);
  wire samp_now = (cnt_r == rise_sample_wait_r) ? sda_s_r : samp_r;
  wire byte_end = hi_end & (bitn_r == 4'd8);
  wire eng_push = byte_end & ~addr_ph_r & rd_r;
  wire last = addr_ph_r ? (remain_r == 16'h0000) : (remain_r == 16'h0001);
  wire host_push = wr & (i_wb_adr[7:0] == `FIFO_OFS) & ~fifo_full & ~eng_push;
  wire host_pop = rdq & (i_wb_adr[7:0] == `FIFO_OFS) & ~fifo_empty & ~ld_now;

  // pins: three stages, a change counts once the last two agree
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      scl_q_r <= 3'b111;
      sda_q_r <= 3'b111;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_q_r <= {scl_q_r[1:0], i_scl};
      sda_q_r <= {sda_q_r[1:0], i_sda};
      if (scl_q_r[1] == scl_q_r[2]) begin
        scl_s_r <= scl_q_r[2];
      end
      if (sda_q_r[1] == sda_q_r[2]) begin
        sda_s_r <= sda_q_r[2];
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      wp_r <= {(DEPTH_LOG2+1){1'b0}};
      rp_r <= {(DEPTH_LOG2+1){1'b0}};
    end else if (fifo_clr) begin
      wp_r <= {(DEPTH_LOG2+1){1'b0}};
      rp_r <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      if (eng_push | host_push) begin
        wp_r <= wp_r + {{DEPTH_LOG2{1'b0}}, 1'b1};
      end
      if (ld_now | host_pop) begin
        rp_r <= rp_r + {{DEPTH_LOG2{1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (eng_push) begin
      // the byte is complete in the shift register by the acknowledge bit
      mem_r[wp_r[DEPTH_LOG2-1:0]] <= sh_r;
    end else if (host_push) begin
      mem_r[wp_r[DEPTH_LOG2-1:0]] <= wd[7:0];
    end
  end

  // configuration registers and bus answer
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      ctl_read_r <= 1'b0;
      addr_r <= 7'h00;
      count_wr_r <= 16'h0000;
      scl_ratio_r <= `RATE_RST;
      rise_sample_wait_r <= `RISE_RST;
      fall_launch_wait_r <= `FALL_RST;
      stretch_limit_r <= `LIMIT_RST;
    end else begin
      o_wb_ack <= req;
      if (wr) begin
        case (i_wb_adr[7:0])
          `CTRL_OFS: if (i_wb_sel[0]) ctl_read_r <= i_wb_dat[`CTRL_READ_BIT];
          `COUNT_OFS: count_wr_r <= (count_wr_r & ~wmask[15:0]) | wd[15:0];
          `ADDR_OFS: if (i_wb_sel[0]) addr_r <= i_wb_dat[6:0];
          `RATE_OFS: scl_ratio_r <= (scl_ratio_r & ~wmask[15:0]) | wd[15:0];
          `EDGE_OFS: begin
            rise_sample_wait_r <= (rise_sample_wait_r & ~wmask[15:0]) | wd[15:0];
            fall_launch_wait_r <= (fall_launch_wait_r & ~wmask[31:16]) | wd[31:16];
          end
          `LIMIT_OFS: stretch_limit_r <= (stretch_limit_r & ~wmask[15:0]) | wd[15:0];
          default: ;
        endcase
      end
      if (rdq) begin
        case (i_wb_adr[7:0])
          `CTRL_OFS: o_wb_dat <= {31'h0000_0000, ctl_read_r};
          `STAT_OFS: o_wb_dat <= {22'h00_0000, stretch_limit_reg_r, err_r, 6'h00, done_r, active};
          `COUNT_OFS: o_wb_dat <= {16'h0000, (active | done_r) ? remain_r : count_wr_r};
          `ADDR_OFS: o_wb_dat <= {25'h000_0000, addr_r};
          `FIFO_OFS: o_wb_dat <= {24'h00_0000, fifo_q};
          `RATE_OFS: o_wb_dat <= {16'h0000, scl_ratio_r};
          `EDGE_OFS: o_wb_dat <= {fall_launch_wait_r, rise_sample_wait_r};
          `LIMIT_OFS: o_wb_dat <= {16'h0000, stretch_limit_r};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // serial engine
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      state_r <= S_IDLE;
      ph_r <= 2'd0;
      cnt_r <= 16'h0000;
      bitn_r <= 4'd0;
      sh_r <= 8'h00;
      hi_r <= 1'b0;
      samp_r <= 1'b1;
      addr_ph_r <= 1'b0;
      rd_r <= 1'b0;
      rs_pend_r <= 1'b0;
      remain_r <= 16'h0000;
      str_cnt_r <= 16'h0000;
      str_per_r <= 16'h0000;
      done_r <= 1'b0;
      err_r <= 1'b0;
      stretch_limit_reg_r <= 1'b0;
      o_scl <= 1'b0;
      o_sda <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      // clears first so that a set in the same cycle wins
      if (wr_stat & wd[`STAT_DONE_BIT]) done_r <= 1'b0;
      if (wr_stat & wd[`STAT_ERR_BIT]) err_r <= 1'b0;
      if (wr_stat & wd[`STAT_STRETCH_LIMIT_REG_BIT]) stretch_limit_reg_r <= 1'b0;
      if (go & active & ctl_read_r_nxt) rs_pend_r <= 1'b1;
      case (state_r)
        S_IDLE: begin
          o_scl_oe <= 1'b0;
          o_sda_oe <= 1'b0;
          rs_pend_r <= 1'b0;
          if (go) begin
            state_r <= S_START;
            // clock goes low on the go edge so the first low half is not a cycle short
            o_scl_oe <= 1'b1;
            ph_r <= 2'd0;
            cnt_r <= 16'h0000;
            rd_r <= ctl_read_r_nxt;
            sh_r <= {addr_r_nxt, ctl_read_r_nxt};
            addr_ph_r <= 1'b1;
            remain_r <= count_wr_r;
          end
        end
        S_START: begin
          // clock low with data released, then clock up, then data down
          cnt_r <= cnt_r + 16'h0001;
          if (ph_r == 2'd0) begin
            o_scl_oe <= 1'b1;
            o_sda_oe <= 1'b0;
          end
          if (cnt_r == half_m1) begin
            cnt_r <= 16'h0000;
            ph_r <= ph_r + 2'd1;
            if (ph_r == 2'd0) o_scl_oe <= 1'b0;
            if (ph_r == 2'd1) o_sda_oe <= 1'b1;
            if (ph_r == 2'd2) begin
              state_r <= S_BIT;
              ph_r <= 2'd0;
              bitn_r <= 4'd0;
              hi_r <= 1'b0;
              o_scl_oe <= 1'b1;
            end
          end
        end
        S_BIT: begin
          if (ph_r == 2'd0) begin
            if (!stall) begin
              if (ld_now) sh_r <= fifo_q;
              if (cnt_r == fall_launch_wait_r) o_sda_oe <= drive_low;
              cnt_r <= cnt_r + 16'h0001;
              if (cnt_r == half_m1) begin
                cnt_r <= 16'h0000;
                ph_r <= 2'd1;
                o_scl_oe <= 1'b0;
                hi_r <= 1'b0;
                str_cnt_r <= 16'h0000;
                str_per_r <= 16'h0000;
              end
            end
          end else if (!hi_r) begin
            // line still low after release: the slave is stretching
            if (scl_s_r) begin
              hi_r <= 1'b1;
            end else if (stretch_limit_r != 16'h0000) begin
              str_cnt_r <= str_cnt_r + 16'h0001;
              if (str_cnt_r == div_m1) begin
                str_cnt_r <= 16'h0000;
                str_per_r <= str_per_r + 16'h0001;
                if ((str_per_r + 16'h0001) == stretch_limit_r) begin
                  stretch_limit_reg_r <= 1'b1;
                  hi_r <= 1'b1;
                end
              end
            end
          end else begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == rise_sample_wait_r) samp_r <= sda_s_r;
            if (hi_end) begin
              cnt_r <= 16'h0000;
              ph_r <= 2'd0;
              hi_r <= 1'b0;
              o_scl_oe <= 1'b1;
              bitn_r <= bitn_r + 4'd1;
              if (bitn_r < 4'd8) sh_r <= {sh_r[6:0], samp_now};
              if (byte_end) begin
                bitn_r <= 4'd0;
                if (we_send & samp_now) begin
                  err_r <= 1'b1;
                  state_r <= S_STOP;
                end else begin
                  if (!addr_ph_r) remain_r <= remain_r - 16'h0001;
                  addr_ph_r <= 1'b0;
                  if (last) begin
                    if (rs_pend_r) begin
                      state_r <= S_START;
                      rd_r <= 1'b1;
                      sh_r <= {addr_r, 1'b1};
                      addr_ph_r <= 1'b1;
                      remain_r <= count_wr_r;
                      rs_pend_r <= 1'b0;
                    end else begin
                      state_r <= S_STOP;
                    end
                  end
                end
              end
            end
          end
        end
        S_STOP: begin
          cnt_r <= cnt_r + 16'h0001;
          if (ph_r == 2'd0) begin
            o_scl_oe <= 1'b1;
            o_sda_oe <= 1'b1;
          end
          if (cnt_r == half_m1) begin
            cnt_r <= 16'h0000;
            ph_r <= ph_r + 2'd1;
            if (ph_r == 2'd0) o_scl_oe <= 1'b0;
            if (ph_r == 2'd1) o_sda_oe <= 1'b0;
            if (ph_r == 2'd2) begin
              state_r <= S_IDLE;
              ph_r <= 2'd0;
              done_r <= 1'b1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // serial_master

//--- serial_master_assertions.sv
`include "serial_master_defs.vh"
module serial_master_assertions #(parameter AW = 8) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [AW-1:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire i_scl,
  input wire o_scl,
  input wire o_scl_oe,
  input wire i_sda,
  input wire o_sda,
  input wire o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rate_r, fw_r, lim_r;
  logic [31:0] lo_cnt, hi_cnt, st_cnt;
  wire wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  wire [31:0] half = (rate_r[15:1] == 15'h0) ? 32'h4000 : {17'h0, rate_r[15:1]};
  // register shadows follow bus writes so timing checks track the programmed values
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      rate_r <= `RATE_RST;
      fw_r <= `FALL_RST;
      lim_r <= `LIMIT_RST;
      lo_cnt <= '0;
      hi_cnt <= '0;
      st_cnt <= '0;
    end else begin
      if (wr && i_wb_adr == `RATE_OFS) rate_r <= i_wb_dat[15:0];
      if (wr && i_wb_adr == `EDGE_OFS) fw_r <= i_wb_dat[31:16];
      if (wr && i_wb_adr == `LIMIT_OFS) lim_r <= i_wb_dat[15:0];
      lo_cnt <= o_scl_oe ? lo_cnt + 1 : '0;
      hi_cnt <= o_scl_oe ? '0 : hi_cnt + 1;
      st_cnt <= (!o_scl_oe && !i_scl) ? st_cnt + 1 : '0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ack_once;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_ack_next;
    s_req |=> s_ack_once;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
  property p_ack_cause;
    $rose(o_wb_ack) |-> $past(i_wb_cyc) && $past(i_wb_stb);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_reset_quiet;
    $rose(i_rst_b) |-> !o_wb_ack && !o_scl_oe && !o_sda_oe;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_unmapped_zero;
    o_wb_ack && $past(i_wb_adr) > 8'h1c && !$past(i_wb_we) |-> o_wb_dat == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_scl_low;
    $fell(o_scl_oe) |-> lo_cnt == half;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low time wrong");
  property p_scl_high;
    $rose(o_scl_oe) |-> hi_cnt >= half;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high time short");
  property p_sda_launch;
    $changed(o_sda_oe) && o_scl_oe && $past(o_scl_oe)
      |-> lo_cnt <= 2 || (lo_cnt >= fw_r && lo_cnt <= fw_r + 2);
  endproperty
  a_sda_launch: assert property (p_sda_launch) else $error("sda launched off delay");
  property p_stretch_bound;
    lim_r == 16'h0 || st_cnt <= (lim_r + 1) * 2 * half + 8;
  endproperty
  a_stretch_bound: assert property (p_stretch_bound) else $error("stretch wait unbounded");
endmodule // serial_master_assertions
bind serial_master serial_master_assertions #(.AW(AW)) u_chk (.i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe));

//--- serial_master_defs.vh
`ifndef SERIAL_MASTER_DEFS_VH
`define SERIAL_MASTER_DEFS_VH

// register byte offsets
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define COUNT_OFS 8'h08
`define ADDR_OFS 8'h0c
`define FIFO_OFS 8'h10
`define RATE_OFS 8'h14
`define EDGE_OFS 8'h18
`define LIMIT_OFS 8'h1c

// control fields
`define CTRL_READ_BIT 0
`define CTRL_CLEAR_BIT 4
`define CTRL_GO_BIT 7

// status fields
`define STAT_ACTIVE_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ERR_BIT 8
`define STAT_STRETCH_LIMIT_REG_BIT 9

// edge wait fields
`define EDGE_RISE_LSB 0
`define EDGE_FALL_LSB 16

// reset values
`define RATE_RST 16'h05dc
`define RISE_RST 16'h0030
`define FALL_RST 16'h0030
`define LIMIT_RST 16'h0040

// divisor used when the ratio is zero
`define RATE_ZERO_DIV 16'h8000

`endif

//--- twowire_slave.sv
module twowire_slave (
  input wire i_scl,
  input wire i_sda,
  input wire i_hold,
  output logic o_scl_low,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] seen [0:15];
  int seen_n = 0;
  int pos = 9;
  int nb = 0;
  logic rd = 1'b0;
  logic quit = 1'b0;
  assign o_scl_low = i_hold;
  initial o_sda_low = 1'b0;
  always @(negedge i_sda) if (i_scl) begin
    pos = -1;
    nb = 0;
    rd = 1'b0;
    quit = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) pos = 9;
  always @(posedge i_scl) begin
    if (pos >= 0 && pos < 8) sh = {sh[6:0], i_sda};
    if (pos == 7 && !(rd && nb > 0)) begin
      seen[seen_n] = sh;
      seen_n++;
      if (nb == 0) rd = sh[0];
    end
    if (pos == 8 && rd && nb > 0 && i_sda) quit = 1'b1;
  end
  // pos 9 means idle: edges outside a frame are ignored
  always @(negedge i_scl) if (pos < 9) begin
    if (pos == 8) begin
      pos = 0;
      nb++;
    end else pos++;
    tx = 8'ha5 + nb[7:0] - 8'h1;
    if (pos == 8) o_sda_low <= !(rd && nb > 0);
    else o_sda_low <= rd && nb > 0 && !quit && !tx[7 - pos];
  end
endmodule // twowire_slave
